// file: core/ircm_pkg.sv
// Package for the isochronous receive channel mask block
`default_nettype none
package ircm_pkg;
  localparam logic [7:0] irc_mask_high_set_off = 8'h70;
  localparam logic [7:0] irc_mask_high_clear_off = 8'h74;
  localparam logic [7:0] irc_mask_low_set_off = 8'h78;
  localparam logic [7:0] irc_mask_low_clear_off = 8'h7c;
  localparam logic [31:0] irc_mask_reset = 32'h0000_0000;
  localparam logic [31:0] irc_bad_read = 32'h0000_0000;
  localparam int irc_chan_count = 64;
  localparam int irc_half = 32;

  typedef struct packed {
    logic [5:0] chan;
    logic valid;
  } ircm_query_t;

  typedef struct packed {
    logic hit;
    logic valid;
  } ircm_answer_t;
endpackage
`default_nettype wire

// file: core/ircm_lookup.sv
// Channel number to mask bit lookup
`timescale 1ns/1ps
`default_nettype none
module ircm_lookup
(
  // Masks
  input wire logic [31:0] mask_low,
  input wire logic [31:0] mask_high,
  // Query
  input wire logic [5:0] chan,
  output logic enabled,
  // Flat view
  output logic [63:0] chan_vec
);
  genvar i;
  generate
    for (i = 0; i < ircm_pkg::irc_half; i = i + 1)
    begin : g_map
      assign chan_vec[i] = mask_low[i];
      assign chan_vec[i + ircm_pkg::irc_half] = mask_high[i];
    end
  endgenerate
  assign enabled = chan_vec[chan];
endmodule // ircm_lookup
`default_nettype wire

// file: core/ircm_top.sv
// APB register bank of isochronous receive channel masks
`timescale 1ns/1ps
`default_nettype none
module ircm_top
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Packet filter query from receive path
  input wire ircm_pkg::ircm_query_t query,
  output ircm_pkg::ircm_answer_t answer,
  // Mask contents
  output logic [63:0] chan_enable_vec
);
  logic [31:0] mask_low;
  logic [31:0] mask_high;
  logic [31:0] next_prdata;
  logic next_err;
  logic setup;
  logic wr;
  logic hit;
  logic [63:0] vec;

  // Zero wait states; answer in the cycle after setup
  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite;

  // Contents are undefined to software; zero reset keeps simulation clean
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_high <= ircm_pkg::irc_mask_reset;
    else if (wr && paddr == ircm_pkg::irc_mask_high_set_off)
      mask_high <= mask_high | pwdata;
    else if (wr && paddr == ircm_pkg::irc_mask_high_clear_off)
      mask_high <= mask_high & ~pwdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_low <= ircm_pkg::irc_mask_reset;
    else if (wr && paddr == ircm_pkg::irc_mask_low_set_off)
      mask_low <= mask_low | pwdata;
    else if (wr && paddr == ircm_pkg::irc_mask_low_clear_off)
      mask_low <= mask_low & ~pwdata;
  end

  always_comb
  begin
    next_err = 1'b0;
    case (paddr)
      ircm_pkg::irc_mask_high_set_off,
      ircm_pkg::irc_mask_high_clear_off: next_prdata = mask_high;
      ircm_pkg::irc_mask_low_set_off,
      ircm_pkg::irc_mask_low_clear_off: next_prdata = mask_low;
      default:
      begin
        next_prdata = ircm_pkg::irc_bad_read;
        next_err = 1'b1;
      end
    endcase
  end

  // Registered answer; pready high only in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && next_err;
      prdata <= (setup && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  ircm_lookup u_lookup
  (
    .mask_low(mask_low),
    .mask_high(mask_high),
    .chan(query.chan),
    .enabled(hit),
    .chan_vec(vec)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      answer <= '0;
      chan_enable_vec <= 64'h0;
    end
    else
    begin
      answer.valid <= query.valid;
      answer.hit <= query.valid && hit;
      chan_enable_vec <= vec;
    end
  end
endmodule // ircm_top
`default_nettype wire

// file: test/ircm_properties.sv
// Mask checker
`timescale 1ns/1ps
`default_nettype none
module ircm_properties
(
  // Watched
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [63:0] chan_enable_vec
);
  logic [63:0] v, e;
  logic w;
  assign v = chan_enable_vec;
  assign e = paddr[3] ? {32'h0, pwdata} : {pwdata, 32'h0};
  // Only aligned words in the 70h..7Ch window are mapped
  assign w = psel && penable && paddr[7:4] == 4'h7 && paddr[1:0] == 2'h0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_mask_set: assert property (w && pwrite && !paddr[2]
    |=> ##1 v == ($past(v, 2) | $past(e, 2))) else $error("set");
  a_mask_clear: assert property (w && pwrite && paddr[2]
    |=> ##1 v == ($past(v, 2) & ~$past(e, 2))) else $error("clear");
  a_read_mask: assert property (w && !pwrite
    |-> prdata == (paddr[3] ? v[31:0] : v[63:32])) else $error("read");
  a_ready_follows: assert property (psel && !penable |=> pready) else $error("ready");
  a_err_unmapped: assert property (pready |-> pslverr == !w) else $error("slverr");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
  cover property (w && pwrite);
  cover property (w && !pwrite);
  cover property (w && paddr[2]);
endmodule // ircm_properties
bind ircm_top ircm_properties u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .chan_enable_vec);
`default_nettype wire

// file: test/ircm_top_tb_top.sv
// Bench
`timescale 1ns/1ps
`default_nettype none
module ircm_top_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] a, paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, s = 32'h24;
  logic [63:0] vec, e, m = 64'h0;
  ircm_pkg::ircm_query_t query = '0;
  ircm_pkg::ircm_answer_t answer;
  int mismatches = 0, num_checks = 0;
  ircm_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .query, .answer, .chan_enable_vec(vec));
  initial forever #2.5 pclk = ~pclk;
  initial #40000 tally_and_finish(1);
  function automatic logic [31:0] lf(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [63:0] g, x);
    num_checks++;
    mismatches += (g !== x);
    if (g !== x)
      $display("mismatch %0t compared value differs", $time);
  endtask
  task automatic tally_and_finish(input int t);
    mismatches += t;
    $display("%0d/%0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= s;
    @(posedge pclk) penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    chk(pslverr, !a[4]);
    if (!w) chk(prdata, a[4] ? (a[3] ? m[31:0] : m[63:32]) : 64'h0);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    // Masks start undefined: clear every channel before use
    s = 32'hffff_ffff;
    a = 8'h74;
    xfer(1'h1);
    a = 8'h7c;
    xfer(1'h1);
    s = 32'h24;
    repeat (400)
    begin
      s = lf(s);
      a = {3'h3, |s[5:4], s[3:2], 2'h0};
      e = a[3] ? {32'h0, s} : {s, 32'h0};
      query <= {s[15:10], 1'h1};
      xfer(1'h1);
      if (a[4]) m = a[2] ? m & ~e : m | e;
      xfer(1'h0);
      chk(answer.hit, m[s[15:10]]);
      chk(answer.valid, 64'h1);
      chk(vec, m);
    end
    tally_and_finish(0);
  end
endmodule // ircm_top_tb_top
`default_nettype wire
